//--- design/cbs_pkg.sv
// Summary of operation
// - sof edge on idle bus: hard sync
// - hard sync: edge quantum becomes sync_segment
// - resync lengthens ph1 or shortens ph2
// - correction per resync limited to sjw
// - one synchronization per bit only
// - level after edge differs from last sample
// - sync on recessive-dominant edge passing both checks
// - edge in interframe space: hard sync
// - other falling edges, except own dominant echo: resynchronization
// - no resync on own dominant echo
// - bit: sync, propagation, ph1, ph2 segments
// - bus level latched at end of ph1
// - phase_segment_two limited to two..eight quanta
// - sjw is maximum correction per resync
package cbs_pkg;
  localparam logic [7:0] CBS_OFF_CTRL = 8'h00;
  localparam logic [7:0] CBS_OFF_TIMING = 8'h04;
  localparam logic [7:0] CBS_OFF_STATUS = 8'h08;
  localparam logic [7:0] CBS_OFF_HCNT = 8'h0C;
  localparam logic [7:0] CBS_OFF_RCNT = 8'h10;

  localparam int CBS_CTRL_EN_BIT = 0;
  localparam int CBS_ST_BIT_POS = 0;
  localparam int CBS_ST_SEG_LSB = 1;
  localparam int CBS_ST_DONE_POS = 3;
  localparam int CBS_ST_EN_POS = 4;

  localparam logic CBS_RST_ENABLE = 1'b0;
  localparam logic [7:0] CBS_RST_BRP = 8'h04;
  localparam logic [3:0] CBS_RST_PROP = 4'h1;
  localparam logic [3:0] CBS_RST_PS1 = 4'h4;
  localparam logic [3:0] CBS_RST_PS2 = 4'h4;
  localparam logic [2:0] CBS_RST_SJW = 3'h1;

  localparam logic [3:0] CBS_PROP_MIN = 4'h1;
  localparam logic [3:0] CBS_PROP_MAX = 4'h8;
  localparam logic [3:0] CBS_PS1_MIN = 4'h1;
  localparam logic [3:0] CBS_PS1_MAX = 4'h8;
  localparam logic [3:0] CBS_PS2_MIN = 4'h2;
  localparam logic [3:0] CBS_PS2_MAX = 4'h8;
  localparam logic [3:0] CBS_SJW_MIN = 4'h1;
  localparam logic [3:0] CBS_SJW_MAX = 4'h4;

  localparam logic CBS_RECESSIVE = 1'b1;
  localparam logic CBS_DOMINANT = 1'b0;

  typedef enum logic [1:0] {CBS_SYNC, CBS_PROP, CBS_PH1, CBS_PH2} cbs_seg_t;

  typedef struct packed {
    logic [2:0] sjw;
    logic [3:0] ps2;
    logic [3:0] ps1;
    logic [3:0] prop;
    logic [7:0] brp;
  } cbs_timing_t;

  typedef struct packed {
    logic en;
    logic done;
    cbs_seg_t seg;
    logic bit_val;
  } cbs_status_t;
endpackage

//--- design/cbs_top.sv
`timescale 1ns/1ps
module cbs_top (
  input wire logic pclk, // apb clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_level, // received bus level, 1 recessive
  input wire logic tx_level, // level this node drives
  input wire logic tx_active, // node is transmitting
  input wire logic frame_idle, // bus idle or ifs, not first intermission bit
  output logic tq_tick, // one pulse per time quantum
  output logic sample_pulse, // pulse at sample point
  output logic sample_bit, // latched bit value
  output logic hard_sync, // pulse on hard synchronization
  output logic resync // pulse on resynchronization
);
  logic enable_r;
  cbs_pkg::cbs_timing_t timing_r;
  logic [7:0] presc_r;
  logic tick_w;
  cbs_pkg::cbs_seg_t seg_r, seg_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [3:0] ext_r, ext_nxt;
  logic [3:0] short_r, short_nxt;
  logic rx_prev_r;
  logic sampled_r;
  logic done_r;
  logic [15:0] hcnt_r;
  logic [15:0] rcnt_r;
  logic do_hard, do_resync, do_sample;
  logic edge_w, ok_w, own_echo_w;
  logic [3:0] prop_len, ps1_len, ps2_len, sjw_len;
  logic [4:0] err_w;
  logic apb_wr, apb_rd;
  logic [31:0] rd_w;
  cbs_pkg::cbs_status_t status_w;

  function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] lo,
                                        input logic [3:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [3:0] min4(input logic [4:0] a, input logic [3:0] b);
    if (a < {1'b0, b}) begin
      return a[3:0];
    end
    return b;
  endfunction

  // effective segment lengths in quanta
  assign prop_len = clamp4(timing_r.prop, cbs_pkg::CBS_PROP_MIN, cbs_pkg::CBS_PROP_MAX);
  assign ps1_len = clamp4(timing_r.ps1, cbs_pkg::CBS_PS1_MIN, cbs_pkg::CBS_PS1_MAX);
  assign ps2_len = clamp4(timing_r.ps2, cbs_pkg::CBS_PS2_MIN, cbs_pkg::CBS_PS2_MAX);
  assign sjw_len = min4({1'b0, clamp4({1'b0, timing_r.sjw}, cbs_pkg::CBS_SJW_MIN,
                                      cbs_pkg::CBS_SJW_MAX)}, ps1_len);

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= cbs_pkg::CBS_RST_ENABLE;
    end else if (apb_wr && paddr == cbs_pkg::CBS_OFF_CTRL) begin
      enable_r <= pwdata[cbs_pkg::CBS_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_r <= '{sjw: cbs_pkg::CBS_RST_SJW, ps2: cbs_pkg::CBS_RST_PS2,
                    ps1: cbs_pkg::CBS_RST_PS1, prop: cbs_pkg::CBS_RST_PROP,
                    brp: cbs_pkg::CBS_RST_BRP};
    end else if (apb_wr && paddr == cbs_pkg::CBS_OFF_TIMING) begin
      timing_r <= pwdata[$bits(cbs_pkg::cbs_timing_t)-1:0];
    end
  end

  assign status_w = '{en: enable_r, done: done_r, seg: seg_r, bit_val: sampled_r};

  always_comb begin
    rd_w = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == cbs_pkg::CBS_OFF_CTRL) begin
      rd_w[cbs_pkg::CBS_CTRL_EN_BIT] = enable_r;
    end else if (paddr == cbs_pkg::CBS_OFF_TIMING) begin
      rd_w[$bits(cbs_pkg::cbs_timing_t)-1:0] = timing_r;
    end else if (paddr == cbs_pkg::CBS_OFF_STATUS) begin
      rd_w[$bits(cbs_pkg::cbs_status_t)-1:0] = status_w;
    end else if (paddr == cbs_pkg::CBS_OFF_HCNT) begin
      rd_w[15:0] = hcnt_r;
    end else if (paddr == cbs_pkg::CBS_OFF_RCNT) begin
      rd_w[15:0] = rcnt_r;
    end else begin
      pslverr = psel & penable;
    end
  end

  // read data registered in the setup cycle, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_w;
    end else if (!apb_rd) begin
      prdata <= 32'h0000_0000;
    end
  end

  // time quantum prescaler: brp+1 clocks per quantum
  // compare with >= so a smaller brp written mid-count cannot stall the quanta
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 8'h00;
    end else if (!enable_r || presc_r >= timing_r.brp) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  assign tick_w = enable_r & (presc_r >= timing_r.brp);

  // edge seen at quantum resolution
  assign edge_w = (rx_prev_r == cbs_pkg::CBS_RECESSIVE) & (rx_level == cbs_pkg::CBS_DOMINANT);
  assign ok_w = edge_w & ~done_r & (sampled_r != rx_level);
  assign own_echo_w = tx_active & (tx_level == cbs_pkg::CBS_DOMINANT);

  always_comb begin
    seg_nxt = seg_r;
    cnt_nxt = cnt_r;
    ext_nxt = ext_r;
    short_nxt = short_r;
    do_hard = 1'b0;
    do_resync = 1'b0;
    do_sample = 1'b0;
    err_w = 5'h00;
    if (tick_w) begin
      if (ok_w && frame_idle) begin
        // edge quantum is the sync_segment, next quantum opens prop
        do_hard = 1'b1;
        seg_nxt = cbs_pkg::CBS_PROP;
        cnt_nxt = 5'h00;
        ext_nxt = 4'h0;
        short_nxt = 4'h0;
      end else begin
        if (ok_w && !own_echo_w) begin
          do_resync = 1'b1;
          case (seg_r)
            cbs_pkg::CBS_PROP: begin
              err_w = cnt_r + 5'h01;
              ext_nxt = min4(err_w, sjw_len);
            end
            cbs_pkg::CBS_PH1: begin
              err_w = {1'b0, prop_len} + cnt_r + 5'h01;
              ext_nxt = min4(err_w, sjw_len);
            end
            cbs_pkg::CBS_PH2: begin
              err_w = {1'b0, ps2_len} - cnt_r;
              short_nxt = min4(err_w, sjw_len);
            end
            default: begin
              err_w = 5'h00;
            end
          endcase
        end
        if (do_resync && seg_r == cbs_pkg::CBS_PH2 && err_w <= {1'b0, sjw_len}) begin
          // early edge within reach: this quantum becomes sync_segment
          seg_nxt = cbs_pkg::CBS_PROP;
          cnt_nxt = 5'h00;
          ext_nxt = 4'h0;
          short_nxt = 4'h0;
        end else begin
          case (seg_r)
            cbs_pkg::CBS_SYNC: begin
              seg_nxt = cbs_pkg::CBS_PROP;
              cnt_nxt = 5'h00;
            end
            cbs_pkg::CBS_PROP: begin
              if (cnt_r == {1'b0, prop_len} - 5'h01) begin
                seg_nxt = cbs_pkg::CBS_PH1;
                cnt_nxt = 5'h00;
              end else begin
                cnt_nxt = cnt_r + 5'h01;
              end
            end
            cbs_pkg::CBS_PH1: begin
              if (cnt_r >= {1'b0, ps1_len} + {1'b0, ext_nxt} - 5'h01) begin
                do_sample = 1'b1;
                seg_nxt = cbs_pkg::CBS_PH2;
                cnt_nxt = 5'h00;
              end else begin
                cnt_nxt = cnt_r + 5'h01;
              end
            end
            default: begin
              if (cnt_r >= {1'b0, ps2_len} - {1'b0, short_nxt} - 5'h01) begin
                seg_nxt = cbs_pkg::CBS_SYNC;
                cnt_nxt = 5'h00;
                ext_nxt = 4'h0;
                short_nxt = 4'h0;
              end else begin
                cnt_nxt = cnt_r + 5'h01;
              end
            end
          endcase
        end
      end
    end
  end

  // bit timing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_r <= cbs_pkg::CBS_SYNC;
      cnt_r <= 5'h00;
      ext_r <= 4'h0;
      short_r <= 4'h0;
    end else if (!enable_r) begin
      seg_r <= cbs_pkg::CBS_SYNC;
      cnt_r <= 5'h00;
      ext_r <= 4'h0;
      short_r <= 4'h0;
    end else begin
      seg_r <= seg_nxt;
      cnt_r <= cnt_nxt;
      ext_r <= ext_nxt;
      short_r <= short_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_r <= cbs_pkg::CBS_RECESSIVE;
    end else if (!enable_r) begin
      rx_prev_r <= cbs_pkg::CBS_RECESSIVE;
    end else if (tick_w) begin
      rx_prev_r <= rx_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_r <= cbs_pkg::CBS_RECESSIVE;
    end else if (!enable_r) begin
      sampled_r <= cbs_pkg::CBS_RECESSIVE;
    end else if (do_sample) begin
      sampled_r <= rx_level;
    end
  end

  // once per bit: set on a sync, cleared at the sample point, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (!enable_r) begin
      done_r <= 1'b0;
    end else if (do_hard || do_resync) begin
      done_r <= 1'b1;
    end else if (do_sample) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_r <= 16'h0000;
      rcnt_r <= 16'h0000;
    end else begin
      if (do_hard) begin
        hcnt_r <= hcnt_r + 16'h0001;
      end
      if (do_resync) begin
        rcnt_r <= rcnt_r + 16'h0001;
      end
    end
  end

  // registered event outputs, one clock after the deciding quantum edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_tick <= 1'b0;
      sample_pulse <= 1'b0;
      hard_sync <= 1'b0;
      resync <= 1'b0;
    end else begin
      tq_tick <= tick_w;
      sample_pulse <= do_sample;
      hard_sync <= do_hard;
      resync <= do_resync;
    end
  end

  assign sample_bit = sampled_r;
endmodule

//--- tb/cbs_top_properties.sv
`timescale 1ns/1ps
module cbs_top_properties (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic pwrite, // write
  input wire logic rx_level, // bus
  input wire logic tx_level, // own level
  input wire logic tx_active, // sending
  input wire logic frame_idle, // idle
  input wire logic tq_tick, // quantum
  input wire logic sample_pulse, // sample
  input wire logic sample_bit, // bit
  input wire logic hard_sync, // hard
  input wire logic resync // resync
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic sync_w;
  logic [1:0] nsync_r;
  assign sync_w = hard_sync | resync;
  // syncs seen since the last sample point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      nsync_r <= 2'h0;
    else if (sample_pulse)
      nsync_r <= {1'b0, sync_w};
    else if (sync_w && nsync_r != 2'h3)
      nsync_r <= nsync_r + 2'h1;
  end
  sequence s_quiet;
    !sample_pulse [*2];
  endsequence
  sequence s_fell;
    !$past(rx_level) || !$past(rx_level, 2);
  endsequence
  sample_gap_a: assert property (sample_pulse |=> s_quiet)
    else $error("sample points too close");
  sample_tick_a: assert property (sample_pulse |-> tq_tick)
    else $error("sample off quantum");
  sync_tick_a: assert property (sync_w |-> tq_tick)
    else $error("sync off quantum");
  sync_kind_a: assert property (!(hard_sync && resync))
    else $error("two sync kinds at once");
  once_bit_a: assert property (sync_w |-> nsync_r == 2'h0 || sample_pulse)
    else $error("second sync in one bit");
  level_diff_a: assert property (sync_w |-> sample_bit == cbs_pkg::CBS_RECESSIVE)
    else $error("sync after dominant sample");
  fall_edge_a: assert property (sync_w |-> s_fell)
    else $error("sync without dominant bus");
  hard_idle_a: assert property (hard_sync |-> $past(frame_idle) || $past(frame_idle, 2))
    else $error("hard sync outside idle");
  resync_busy_a: assert property (resync |-> !$past(frame_idle) && !$past(frame_idle, 2))
    else $error("resync in idle");
  no_echo_a: assert property (resync |-> !($past(tx_active) && !$past(tx_level)))
    else $error("resync on own echo");
  bit_hold_a: assert property ($changed(sample_bit) |-> sample_pulse || $past(psel && pwrite, 2))
    else $error("bit changed off sample");
endmodule
bind cbs_top cbs_top_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .pwrite(pwrite), .rx_level(rx_level), .tx_level(tx_level), .tx_active(tx_active),
  .frame_idle(frame_idle), .tq_tick(tq_tick), .sample_pulse(sample_pulse),
  .sample_bit(sample_bit), .hard_sync(hard_sync), .resync(resync));

//--- tb/cbs_bus_node.sv
`timescale 1ns/1ps
module cbs_bus_node (
  input wire logic pclk, // clock
  output logic rx_level // bus level
);
  // released wired-and bus reads recessive
  initial rx_level = 1'b1;
  task automatic hold(input logic lvl, input int n);
    rx_level <= lvl;
    repeat (n) @(posedge pclk);
  endtask
endmodule

//--- tb/cbs_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module cbs_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, echo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tx_level, tx_active, frame_idle, rx_level, tq_tick, sample_pulse, sample_bit;
  logic hard_sync, resync;
  logic sb[8];
  int st[8];
  int error_cnt, n_checks, cyc, hs_cnt, rs_cnt, hs_t, ns, d, sjw, n_rs;
  cbs_bus_node u_node (.pclk(pclk), .rx_level(rx_level));
  cbs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_level(rx_level), .tx_level(tx_level), .tx_active(tx_active),
    .frame_idle(frame_idle), .tq_tick(tq_tick), .sample_pulse(sample_pulse),
    .sample_bit(sample_bit), .hard_sync(hard_sync), .resync(resync));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (hard_sync === 1'b1) begin
      hs_cnt++;
      hs_t = cyc;
      ns = 0;
    end
    if (resync === 1'b1)
      rs_cnt++;
    if (sample_pulse === 1'b1 && ns < 8) begin
      st[ns] = cyc;
      sb[ns] = sample_bit;
      ns++;
    end
    if (cyc == 6000) begin
      error_cnt++;
      results();
    end
  end
  task results();
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int corr(int dd, int s, logic e);
    if (e)
      return 0;
    if (dd >= 0)
      return (dd < s) ? dd : s;
    return (-dd < s) ? dd : -s;
  endfunction
  // sof, recessive bit shifted by d, dominant bit with glitch, dominant bit after spike
  task automatic frame();
    hs_cnt = 0;
    rs_cnt = 0;
    tx_active <= echo;
    tx_level <= echo ? 1'b0 : 1'($urandom);
    u_node.hold(1'b0, 3);
    frame_idle <= 1'b0;
    u_node.hold(1'b0, 7);
    u_node.hold(1'b1, 10 + d);
    u_node.hold(1'b0, 1);
    u_node.hold(1'b1, 1);
    u_node.hold(1'b0, 7);
    u_node.hold(1'b1, 1);
    u_node.hold(1'b0, 10);
    frame_idle <= 1'b1;
    tx_active <= 1'b0;
    u_node.hold(1'b1, 30);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_level, tx_active, frame_idle} = 3'h5;
    void'($urandom(32'hBBFD5177));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cbs_pkg::CBS_OFF_TIMING, 32'h0);
    `CHK(rd, 32'h00144104)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, cbs_pkg::CBS_OFF_CTRL, 32'h1);
    apb(1'b1, cbs_pkg::CBS_OFF_HCNT, 32'hFFFF);
    for (int i = 0; i < 12; i++) begin
      sjw = (i == 0) ? 1 : 1 + $urandom % 4;
      d = (i == 0) ? 3 : int'($urandom % 7) - 3;
      echo = (i == 1) || ($urandom % 4 == 0);
      if (echo)
        d = 0;
      apb(1'b1, cbs_pkg::CBS_OFF_TIMING, 32'h00044100 | (sjw << 20));
      repeat (20) @(posedge pclk);
      frame();
      `CHK(hs_cnt, 1)
      `CHK(st[0] - hs_t, 5)
      `CHK({sb[0], sb[1], sb[2], sb[3]}, 4'h4)
      `CHK(st[1] - st[0], 10)
      `CHK(st[2] - st[1], 10 + corr(d, sjw, echo))
      `CHK(rs_cnt, echo ? 0 : 1)
      if (!echo)
        n_rs++;
    end
    apb(1'b0, cbs_pkg::CBS_OFF_HCNT, 32'h0);
    `CHK(rd[15:0], 16'h000C)
    apb(1'b0, cbs_pkg::CBS_OFF_RCNT, 32'h0);
    `CHK(rd[15:0], 16'(n_rs))
    apb(1'b0, cbs_pkg::CBS_OFF_STATUS, 32'h0);
    `CHK({rd[4], rd[3], rd[0]}, 3'h5)
    results();
  end
endmodule
